// ==== rtl/ciu_top.sv ====
/*
  Instruction execute unit with its data memory, stack and Wishbone slave.
  Assumes a classic Wishbone master; software writes one instruction
  word to launch it and polls the busy bit.
*/
`timescale 1ns/100ps
module ciu_top
  import ciu_pkg::*;
#(
  parameter int MEM_DEPTH = 256,
  parameter int STACK_DEPTH = 8,
  parameter int PC_W = 13,
  parameter logic [12:0] IRQ_VECTOR = 13'h0004
)(
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic irq_pending_in,
  output logic irq_ack_out,
  output logic clock_stop_out
);
  localparam int AW = $clog2(MEM_DEPTH);
  localparam int SPW = $clog2(STACK_DEPTH) + 1;

  // ------------------------------------------------------------
  // parameter checks
  // ------------------------------------------------------------
  if (MEM_DEPTH < 2 || MEM_DEPTH > 256 || (MEM_DEPTH & (MEM_DEPTH - 1)) != 0) begin : g_bad_mem
    $error("MEM_DEPTH must be a power of two from 2 to 256");
  end
  if (STACK_DEPTH < 1 || PC_W < 8 || PC_W > 13) begin : g_bad_pc
    $error("STACK_DEPTH must be positive and PC_W within 8 to 13");
  end

  typedef struct packed {
    ciu_state_t state;
    ciu_op_t op;
    logic [7:0] maddr;
    logic [12:0] opnd;
    logic [7:0] w;
    logic c, ac, z, ov, sc, cz, power_down_flag, to, global_interrupt_enable;
    logic halted;
    logic [PC_W-1:0] pc;
    logic [STACK_DEPTH-1:0][PC_W-1:0] stk;
    logic [SPW-1:0] sp;
    logic [MEM_DEPTH-1:0][7:0] mem;
    logic [7:0] bus_maddr;
    logic [7:0] wdt;
    logic [7:0] pre;
    logic ack;
    logic [31:0] dat;
    logic irq_ack;
  } ciu_regs_t;

  ciu_regs_t s;
  ciu_regs_t next_s;

  logic [7:0] alu_res;
  logic alu_wr_w, alu_wr_m, alu_upd_z, alu_upd_c, alu_upd_ar;
  logic alu_c, alu_ac, alu_ov, alu_sc, alu_cz, alu_z;
  logic [7:0] cur_m;
  logic [31:0] wmask;
  logic [2:0] rsel;
  logic bus_req;
  logic [PC_W-1:0] pop_pc;
  logic wdt_wrap;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // one decoder for both the read mux and the write side
  function automatic logic [2:0] reg_sel(input logic [7:0] adr);
    if (adr == CIU_A_INSTR) reg_sel = 3'h0;
    else if (adr == CIU_A_WREG) reg_sel = 3'h1;
    else if (adr == CIU_A_STATUS) reg_sel = 3'h2;
    else if (adr == CIU_A_PC) reg_sel = 3'h3;
    else if (adr == CIU_A_MADDR) reg_sel = 3'h4;
    else if (adr == CIU_A_MDATA) reg_sel = 3'h5;
    else if (adr == CIU_A_STACK) reg_sel = 3'h6;
    else if (adr == CIU_A_WDT) reg_sel = 3'h7;
    else reg_sel = 3'h0;
  endfunction

  function automatic logic mapped(input logic [7:0] adr);
    mapped = (adr[1:0] == 2'b00) && (adr <= CIU_A_WDT);
  endfunction

  function automatic logic [7:0] mem_rd(input ciu_regs_t r, input logic [7:0] a);
    mem_rd = r.mem[a[AW-1:0]];
  endfunction

  assign cur_m = mem_rd(s, s.maddr);
  assign rsel = reg_sel(wb_adr_in);
  assign bus_req = wb_cyc_in & wb_stb_in & ~s.ack;
  // watchdog wrap this cycle; a status write in the same cycle must not hide it
  assign wdt_wrap = !s.halted && s.pre == CIU_PRE_MAX && s.wdt == CIU_PRE_MAX;
  // an empty stack pops slot 0 rather than wrapping
  assign pop_pc = (s.sp == '0) ? s.stk[0] : s.stk[s.sp - SPW'(1)];

  // byte enables become a bit mask for merged writes
  for (genvar i = 0; i < 4; i++) begin : g_mask
    assign wmask[i*8 +: 8] = {8{wb_sel_in[i]}};
  end

  ciu_alu u_alu (
    .op_in(s.op),
    .w_in(s.w),
    .m_in(cur_m),
    .imm_in(s.opnd[7:0]),
    .c_in(s.c),
    .ac_in(s.ac),
    .z_in(s.z),
    .res_out(alu_res),
    .wr_w_out(alu_wr_w),
    .wr_m_out(alu_wr_m),
    .upd_z_out(alu_upd_z),
    .upd_c_out(alu_upd_c),
    .upd_ar_out(alu_upd_ar),
    .c_out(alu_c),
    .ac_out(alu_ac),
    .ov_out(alu_ov),
    .sc_out(alu_sc),
    .cz_out(alu_cz),
    .z_out(alu_z)
  );

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.ack = 1'b0;
    next_s.irq_ack = 1'b0;
    // watchdog and prescaler freeze while the clock is stopped
    if (!s.halted) begin
      next_s.pre = s.pre + CIU_ONE;
      if (s.pre == CIU_PRE_MAX) begin
        next_s.wdt = s.wdt + CIU_ONE;
        if (s.wdt == CIU_PRE_MAX) next_s.to = 1'b1;
      end
    end
    case (s.state)
      CIU_ST_EXEC: begin
        next_s.state = CIU_ST_IDLE;
        next_s.pc = s.pc + PC_W'(1);
        if (alu_wr_w) next_s.w = alu_res;
        if (alu_wr_m) next_s.mem[s.maddr[AW-1:0]] = alu_res;
        if (alu_upd_z) next_s.z = alu_z;
        if (alu_upd_c) next_s.c = alu_c;
        if (alu_upd_ar) begin
          next_s.ac = alu_ac;
          next_s.ov = alu_ov;
          next_s.sc = alu_sc;
          next_s.cz = alu_cz;
        end
        case (s.op)
          CIU_OP_HALT: begin
            next_s.halted = 1'b1;
            next_s.power_down_flag = 1'b1;
            next_s.to = 1'b0;
            next_s.wdt = 8'h00;
            next_s.pre = 8'h00;
          end
          CIU_OP_JMP: begin
            next_s.pc = s.opnd[PC_W-1:0];
            next_s.state = CIU_ST_DUMMY;
          end
          CIU_OP_RET, CIU_OP_RET_I: begin
            next_s.pc = pop_pc;
            if (s.sp != '0) next_s.sp = s.sp - SPW'(1);
            next_s.state = CIU_ST_DUMMY;
          end
          CIU_OP_INTERRUPT_EXIT: begin
            next_s.state = CIU_ST_DUMMY;
            if (irq_pending_in) begin
              // return address stays stacked; the handler runs first
              next_s.pc = IRQ_VECTOR[PC_W-1:0];
              next_s.irq_ack = 1'b1;
            end else begin
              next_s.pc = pop_pc;
              next_s.global_interrupt_enable = 1'b1;
              if (s.sp != '0) next_s.sp = s.sp - SPW'(1);
            end
          end
          default: ;
        endcase
      end
      CIU_ST_DUMMY: next_s.state = CIU_ST_IDLE; // inserted dummy cycle
      default: ;
    endcase
    // register reads take a snapshot at the request edge
    next_s.dat = 32'h0000_0000;
    if (bus_req && mapped(wb_adr_in) && !wb_we_in) begin
      case (rsel)
        3'h0: next_s.dat = {3'h0, s.opnd, s.maddr, 2'h0, s.op};
        3'h1: next_s.dat = {24'h0, s.w};
        3'h2: next_s.dat = {21'h0, s.halted, s.state != CIU_ST_IDLE, s.global_interrupt_enable,
                            s.cz, s.sc, s.to, s.power_down_flag, s.ov, s.z, s.ac, s.c};
        3'h3: next_s.dat = 32'(s.pc);
        3'h4: next_s.dat = {24'h0, s.bus_maddr};
        3'h5: next_s.dat = {24'h0, mem_rd(s, s.bus_maddr)};
        3'h6: next_s.dat = 32'(s.sp);
        default: next_s.dat = {16'h0, s.pre, s.wdt};
      endcase
    end
    if (bus_req) next_s.ack = 1'b1;
    // writes are taken only while the unit is idle
    if (bus_req && wb_we_in && mapped(wb_adr_in) && s.state == CIU_ST_IDLE) begin
      case (rsel)
        3'h0: begin
          if (s.halted) begin
            next_s.halted = 1'b0; // wake only, nothing executes
          end else if (wb_sel_in != 4'h0) begin
            next_s.op = ciu_op_t'(wb_dat_in[5:0]);
            next_s.maddr = wb_dat_in[CIU_F_MADDR +: 8];
            next_s.opnd = wb_dat_in[CIU_F_OPND +: 13];
            next_s.state = CIU_ST_EXEC;
          end
        end
        3'h1: if (wb_sel_in[0]) next_s.w = wb_dat_in[7:0];
        3'h2: begin
          if (wb_sel_in[0]) begin
            next_s.c = wb_dat_in[CIU_B_C];
            next_s.ac = wb_dat_in[CIU_B_AC];
            next_s.z = wb_dat_in[CIU_B_Z];
            next_s.ov = wb_dat_in[CIU_B_OV];
            next_s.power_down_flag = wb_dat_in[CIU_B_PDF];
            next_s.to = wb_dat_in[CIU_B_TO] | wdt_wrap; // set wins over clear
            next_s.sc = wb_dat_in[CIU_B_SC];
            next_s.cz = wb_dat_in[CIU_B_CZ];
          end
          if (wb_sel_in[1]) next_s.global_interrupt_enable = wb_dat_in[CIU_B_EMI];
        end
        3'h3: next_s.pc = PC_W'((32'(s.pc) & ~wmask) | (wb_dat_in & wmask));
        3'h4: if (wb_sel_in[0]) next_s.bus_maddr = wb_dat_in[7:0];
        3'h5: if (wb_sel_in[0]) next_s.mem[s.bus_maddr[AW-1:0]] = wb_dat_in[7:0];
        3'h6: begin
          // a push on a full stack is dropped
          if (wb_sel_in != 4'h0 && 32'(s.sp) < STACK_DEPTH) begin
            next_s.stk[s.sp] = wb_dat_in[PC_W-1:0];
            next_s.sp = s.sp + SPW'(1);
          end
        end
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  // memory is kept out of reset so power-down and reset keep it
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      s <= next_s;
      s.state <= CIU_ST_IDLE;
      s.op <= CIU_OP_IDLE;
      s.maddr <= 8'h00;
      s.opnd <= 13'h0000;
      s.w <= 8'h00;
      {s.c, s.ac, s.z, s.ov, s.sc, s.cz, s.power_down_flag, s.to, s.global_interrupt_enable} <= 9'h000;
      s.halted <= 1'b0;
      s.pc <= '0;
      s.stk <= '0;
      s.sp <= '0;
      s.bus_maddr <= 8'h00;
      s.wdt <= 8'h00;
      s.pre <= 8'h00;
      s.ack <= 1'b0;
      s.dat <= 32'h0000_0000;
      s.irq_ack <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  assign wb_ack_out = s.ack;
  assign wb_dat_out = s.dat;
  assign irq_ack_out = s.irq_ack;
  assign clock_stop_out = s.halted;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  logic exec_now;
  logic [8:0] sbc_need;
  assign exec_now = (s.state == CIU_ST_EXEC);
  assign sbc_need = {1'b0, cur_m} + {8'h00, ~s.c};

  property p_inv_m;
    exec_now && s.op == CIU_OP_INV_M |=>
      s.mem[$past(s.maddr)] == ~$past(cur_m) && s.c == $past(s.c);
  endproperty
  a_inv_m: assert property (p_inv_m) else $error("invert to memory wrong");

  property p_inv_w;
    exec_now && s.op == CIU_OP_INV_W |=>
      s.w == ~$past(cur_m) && cur_m == $past(cur_m) && s.z == (s.w == 8'h00);
  endproperty
  a_inv_w: assert property (p_inv_w) else $error("invert to w wrong");

  property p_daa_lo;
    exec_now && s.op == CIU_OP_DAA && !s.ac && s.w[3:0] <= CIU_NIB_LIM[3:0] |=>
      s.mem[$past(s.maddr)][3:0] == $past(s.w[3:0]);
  endproperty
  a_daa_lo: assert property (p_daa_lo) else $error("adjust low nibble wrong");

  property p_daa_c;
    exec_now && s.op == CIU_OP_DAA && s.c |=> s.c && s.z == $past(s.z);
  endproperty
  a_daa_c: assert property (p_daa_c) else $error("adjust lost carry");

  property p_dec_m;
    exec_now && s.op == CIU_OP_DEC_M |=>
      s.mem[$past(s.maddr)] == $past(cur_m) - CIU_ONE;
  endproperty
  a_dec_m: assert property (p_dec_m) else $error("decrement wrong");

  property p_inc_w;
    exec_now && s.op == CIU_OP_INC_W |=>
      s.w == $past(cur_m) + CIU_ONE && s.z == (s.w == 8'h00);
  endproperty
  a_inc_w: assert property (p_inc_w) else $error("increment to w wrong");

  property p_halt;
    exec_now && s.op == CIU_OP_HALT |=>
      clock_stop_out && s.power_down_flag && !s.to && s.wdt == 8'h00 && s.pre == 8'h00;
  endproperty
  a_halt: assert property (p_halt) else $error("power down entry wrong");

  sequence s_dummy_then_idle;
    s.state == CIU_ST_DUMMY ##1 s.state == CIU_ST_IDLE;
  endsequence
  property p_jmp;
    exec_now && s.op == CIU_OP_JMP |=>
      s.pc == $past(s.opnd[PC_W-1:0]) and s_dummy_then_idle;
  endproperty
  a_jmp: assert property (p_jmp) else $error("jump timing or target wrong");

  property p_interrupt_exit;
    exec_now && s.op == CIU_OP_INTERRUPT_EXIT && !irq_pending_in |=> s.global_interrupt_enable && !irq_ack_out;
  endproperty
  a_interrupt_exit: assert property (p_interrupt_exit) else $error("interrupt exit enable wrong");

  property p_rlc;
    exec_now && s.op == CIU_OP_ROTATE_LEFT_THRU_CARRY_TO_W |=>
      s.c == $past(cur_m[7]) && s.w[0] == $past(s.c);
  endproperty
  a_rlc: assert property (p_rlc) else $error("rotate through carry wrong");

  property p_sbc;
    exec_now && s.op == CIU_OP_SBC |=>
      s.c == ({1'b0, $past(s.w)} >= $past(sbc_need));
  endproperty
  a_sbc: assert property (p_sbc) else $error("borrow sense wrong");

  property p_ack;
    wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out ##1 !wb_ack_out;
  endproperty
  a_ack: assert property (p_ack) else $error("bus ack not one cycle");
endmodule

// ==== rtl/ciu_pkg.sv ====
/*
  Constants, opcodes and register map of the instruction execute unit.
  Assumes a 32-bit classic Wishbone slave port on one 25 MHz clock.
*/
// Function
// - invert_memory writes the complemented byte back and updates zero only
// - invert_to_w puts the complemented byte in w; memory and other flags stay
// - decimal_adjust adds 6 to low nibble if above 9 or half carry
// - high nibble gets 6 if above 9 or carry; sum goes to memory
// - decimal_adjust touches only carry, which marks a sum past 100
// - subtract-one forms decrement, update zero, write memory or w
// - add-one forms increment, update zero; w form keeps memory
// - power down halts, stops clock, clears watchdog, sets power_down_flag
// - unconditional_jump loads the address field, two cycles, no flags
// - copy_transfer moves memory, immediate or w with no flag change
// - idle_instruction changes nothing and moves on
// - OR forms combine w with memory or immediate, zero flag only
// - subroutine_exit pops the return address into the program counter
// - subroutine exit with immediate also loads w, flags untouched
// - interrupt_exit pops and sets enable; a pending interrupt goes first
// - rotate_left wraps bit 7 into bit 0, no flags
// - rotate left through carry: bit 7 to carry, carry to bit 0
// - rotate_right wraps bit 0 into bit 7, no flags
// - rotate right through carry: bit 0 to carry, carry to bit 7
// - subtract_with_borrow does w minus memory minus not carry into w
// - carry after subtraction is clear when negative, set otherwise
package ciu_pkg;

  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] CIU_A_INSTR = 8'h00;
  localparam logic [7:0] CIU_A_WREG = 8'h04;
  localparam logic [7:0] CIU_A_STATUS = 8'h08;
  localparam logic [7:0] CIU_A_PC = 8'h0c;
  localparam logic [7:0] CIU_A_MADDR = 8'h10;
  localparam logic [7:0] CIU_A_MDATA = 8'h14;
  localparam logic [7:0] CIU_A_STACK = 8'h18;
  localparam logic [7:0] CIU_A_WDT = 8'h1c;

  // ------------------------------------------------------------
  // status bit positions
  // ------------------------------------------------------------
  localparam int CIU_B_C = 0;
  localparam int CIU_B_AC = 1;
  localparam int CIU_B_Z = 2;
  localparam int CIU_B_OV = 3;
  localparam int CIU_B_PDF = 4;
  localparam int CIU_B_TO = 5;
  localparam int CIU_B_SC = 6;
  localparam int CIU_B_CZ = 7;
  localparam int CIU_B_EMI = 8;
  localparam int CIU_B_BUSY = 9;
  localparam int CIU_B_HALT = 10;

  // ------------------------------------------------------------
  // instruction word fields and arithmetic constants
  // ------------------------------------------------------------
  localparam int CIU_F_MADDR = 8;
  localparam int CIU_F_OPND = 16;
  localparam logic [7:0] CIU_NIB_LIM = 8'h09;
  localparam logic [7:0] CIU_ADJ_LO = 8'h06;
  localparam logic [7:0] CIU_ADJ_HI = 8'h60;
  localparam logic [7:0] CIU_ONE = 8'h01;
  localparam logic [7:0] CIU_PRE_MAX = 8'hff;

  typedef enum logic [5:0] {
    CIU_OP_IDLE = 6'h00, CIU_OP_INV_M = 6'h01, CIU_OP_INV_W = 6'h02,
    CIU_OP_DAA = 6'h03, CIU_OP_DEC_M = 6'h04, CIU_OP_DEC_W = 6'h05,
    CIU_OP_INC_M = 6'h06, CIU_OP_INC_W = 6'h07, CIU_OP_HALT = 6'h08,
    CIU_OP_JMP = 6'h09, CIU_OP_MOV_MW = 6'h0a, CIU_OP_MOV_IW = 6'h0b,
    CIU_OP_MOV_WM = 6'h0c, CIU_OP_OR_W = 6'h0d, CIU_OP_OR_I = 6'h0e,
    CIU_OP_OR_M = 6'h0f, CIU_OP_RET = 6'h10, CIU_OP_RET_I = 6'h11,
    CIU_OP_INTERRUPT_EXIT = 6'h12, CIU_OP_RL = 6'h13, CIU_OP_RLA = 6'h14,
    CIU_OP_RLC = 6'h15, CIU_OP_ROTATE_LEFT_THRU_CARRY_TO_W = 6'h16, CIU_OP_RR = 6'h17,
    CIU_OP_RRA = 6'h18, CIU_OP_RRC = 6'h19, CIU_OP_ROTATE_RIGHT_THRU_CARRY_TO_W = 6'h1a,
    CIU_OP_SBC = 6'h1b
  } ciu_op_t;

  typedef enum logic [1:0] {CIU_ST_IDLE, CIU_ST_EXEC, CIU_ST_DUMMY} ciu_state_t;

endpackage

// ==== rtl/ciu_alu.sv ====
/*
  Combinational datapath: result and flag values for one instruction.
  Assumes the caller holds the operands stable and applies the write enables.
*/
`timescale 1ns/100ps
module ciu_alu
  import ciu_pkg::*;
(
  input wire ciu_op_t op_in,
  input wire logic [7:0] w_in,
  input wire logic [7:0] m_in,
  input wire logic [7:0] imm_in,
  input wire logic c_in,
  input wire logic ac_in,
  input wire logic z_in,
  output logic [7:0] res_out,
  output logic wr_w_out,
  output logic wr_m_out,
  output logic upd_z_out,
  output logic upd_c_out,
  output logic upd_ar_out,
  output logic c_out,
  output logic ac_out,
  output logic ov_out,
  output logic sc_out,
  output logic cz_out,
  output logic z_out
);
  logic [8:0] diff;
  logic [4:0] ldiff;
  logic [8:0] dsum;
  logic [7:0] adj;

  // ------------------------------------------------------------
  // arithmetic helpers
  // ------------------------------------------------------------
  // borrow-in is the inverted carry
  assign diff = {1'b0, w_in} - {1'b0, m_in} - {8'h00, ~c_in};
  assign ldiff = {1'b0, w_in[3:0]} - {1'b0, m_in[3:0]} - {4'h0, ~c_in};
  // both nibble tests use the w value as it stands
  assign adj = ((w_in[3:0] > CIU_NIB_LIM[3:0]) || ac_in ? CIU_ADJ_LO : 8'h00)
             | ((w_in[7:4] > CIU_NIB_LIM[3:0]) || c_in ? CIU_ADJ_HI : 8'h00);
  assign dsum = {1'b0, w_in} + {1'b0, adj};
  assign z_out = (res_out == 8'h00);

  // ------------------------------------------------------------
  // per-opcode result and write enables
  // ------------------------------------------------------------
  always_comb begin
    res_out = m_in;
    wr_w_out = 1'b0;
    wr_m_out = 1'b0;
    upd_z_out = 1'b0;
    upd_c_out = 1'b0;
    upd_ar_out = 1'b0;
    c_out = c_in;
    ac_out = ~ldiff[4];
    ov_out = (w_in[7] ^ m_in[7]) & (w_in[7] ^ diff[7]);
    sc_out = diff[7] ^ ((w_in[7] ^ m_in[7]) & (w_in[7] ^ diff[7]));
    cz_out = (diff[7:0] == 8'h00) & z_in;
    case (op_in)
      CIU_OP_INV_M: begin res_out = ~m_in; wr_m_out = 1'b1; upd_z_out = 1'b1; end
      CIU_OP_INV_W: begin res_out = ~m_in; wr_w_out = 1'b1; upd_z_out = 1'b1; end
      CIU_OP_DAA: begin
        res_out = dsum[7:0];
        wr_m_out = 1'b1;
        upd_c_out = 1'b1;
        c_out = c_in | dsum[8];
      end
      CIU_OP_DEC_M: begin res_out = m_in - CIU_ONE; wr_m_out = 1'b1; upd_z_out = 1'b1; end
      CIU_OP_DEC_W: begin res_out = m_in - CIU_ONE; wr_w_out = 1'b1; upd_z_out = 1'b1; end
      CIU_OP_INC_M: begin res_out = m_in + CIU_ONE; wr_m_out = 1'b1; upd_z_out = 1'b1; end
      CIU_OP_INC_W: begin res_out = m_in + CIU_ONE; wr_w_out = 1'b1; upd_z_out = 1'b1; end
      CIU_OP_MOV_MW: begin res_out = m_in; wr_w_out = 1'b1; end
      CIU_OP_MOV_IW, CIU_OP_RET_I: begin res_out = imm_in; wr_w_out = 1'b1; end
      CIU_OP_MOV_WM: begin res_out = w_in; wr_m_out = 1'b1; end
      CIU_OP_OR_W: begin res_out = w_in | m_in; wr_w_out = 1'b1; upd_z_out = 1'b1; end
      CIU_OP_OR_I: begin res_out = w_in | imm_in; wr_w_out = 1'b1; upd_z_out = 1'b1; end
      CIU_OP_OR_M: begin res_out = w_in | m_in; wr_m_out = 1'b1; upd_z_out = 1'b1; end
      CIU_OP_RL, CIU_OP_RLA: begin
        res_out = {m_in[6:0], m_in[7]};
        wr_m_out = (op_in == CIU_OP_RL);
        wr_w_out = (op_in == CIU_OP_RLA);
      end
      CIU_OP_RLC, CIU_OP_ROTATE_LEFT_THRU_CARRY_TO_W: begin
        res_out = {m_in[6:0], c_in};
        c_out = m_in[7];
        upd_c_out = 1'b1;
        wr_m_out = (op_in == CIU_OP_RLC);
        wr_w_out = (op_in == CIU_OP_ROTATE_LEFT_THRU_CARRY_TO_W);
      end
      CIU_OP_RR, CIU_OP_RRA: begin
        res_out = {m_in[0], m_in[7:1]};
        wr_m_out = (op_in == CIU_OP_RR);
        wr_w_out = (op_in == CIU_OP_RRA);
      end
      CIU_OP_RRC, CIU_OP_ROTATE_RIGHT_THRU_CARRY_TO_W: begin
        res_out = {c_in, m_in[7:1]};
        c_out = m_in[0];
        upd_c_out = 1'b1;
        wr_m_out = (op_in == CIU_OP_RRC);
        wr_w_out = (op_in == CIU_OP_ROTATE_RIGHT_THRU_CARRY_TO_W);
      end
      CIU_OP_SBC: begin
        res_out = diff[7:0];
        wr_w_out = 1'b1;
        upd_z_out = 1'b1;
        upd_c_out = 1'b1;
        upd_ar_out = 1'b1;
        c_out = ~diff[8];
      end
      default: res_out = m_in; // idle, jump, plain and interrupt exits, halt
    endcase
  end
endmodule

// ==== verif/ciu_irq_src.sv ====
/*
  Interrupt source beside the execute unit.
  Assumes irq_ack_in is a one-cycle pulse on a divert to the vector.
*/
`timescale 1ns/100ps
module ciu_irq_src (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic req_in,
  input wire logic irq_ack_in,
  output logic irq_pending_out,
  output logic [7:0] acks_out
);
  // pending stays up until serviced, as a real source would not give up
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      irq_pending_out <= 1'b0;
      acks_out <= 8'h00;
    end else begin
      if (req_in) irq_pending_out <= 1'b1;
      if (irq_ack_in) begin
        irq_pending_out <= 1'b0;
        acks_out <= acks_out + 8'h01;
      end
    end
  end
endmodule

// ==== verif/cpu_instruction_execute_unit_tb.sv ====
/*
  Bench for ciu_top: random data ops with corners, branches, power down.
  Assumes the zero-wait Wishbone slave and register map of the note.
*/
`timescale 1ns/100ps
module cpu_instruction_execute_unit_tb
  import ciu_pkg::*;
;
  logic clock, rst, cyc, stb, we, ack, irq_req, irq, iack, cstop;
  logic [7:0] adr, w, m, a, i, s, n_ack;
  logic [3:0] sel;
  logic [31:0] dat, rdat, q;
  logic [23:0] e;
  logic [12:0] t;
  logic [5:0] op;
  int err_count, samples_checked;
  integer seed;

  ciu_top i_ciu_top (.clock_in(clock), .sys_rst_in(rst), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat), .wb_dat_out(rdat),
    .wb_ack_out(ack), .irq_pending_in(irq), .irq_ack_out(iack), .clock_stop_out(cstop));
  ciu_irq_src i_ciu_irq_src (.clock_in(clock), .sys_rst_in(rst), .req_in(irq_req),
    .irq_ack_in(iack), .irq_pending_out(irq), .acks_out(n_ack));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // --------
  // bus and check tasks
  // --------
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", n, exp, got);
    end
  endtask
  // request held until ack is sampled; cyc drops on that same edge
  task automatic wb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    int k;
    @(posedge clock);
    {cyc, stb, we, adr, sel, dat} <= {2'b11, wr, ad, 4'hf, d};
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (ack !== 1'b1 && k < 40);
    // a missing ack is a failure, not a silent fall-through
    if (ack !== 1'b1) err_count++;
    q = rdat;
    {cyc, stb} <= 2'b00;
  endtask
  // writes while busy are dropped, so poll busy before going on
  task automatic run(input logic [31:0] d);
    int k;
    wb(1'b1, CIU_A_INSTR, d);
    k = 0;
    do begin
      wb(1'b0, CIU_A_STATUS, 32'h0);
      k++;
    end while (q[CIU_B_BUSY] !== 1'b0 && k < 20);
    if (q[CIU_B_BUSY] !== 1'b0) err_count++;
  endtask
  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // expected {w, m, flags}; d bit0 writes w, bit1 writes memory
  function automatic logic [23:0] model(input logic [5:0] op,
      input logic [7:0] w, m, i, s);
    logic u;
    logic v;
    logic [1:0] d;
    logic [7:0] r, x;
    logic [8:0] t, p;
    logic [4:0] h;
    x = ((w[3:0] > 4'h9 || s[1]) ? 8'h06 : 8'h00) + ((w[7:4] > 4'h9 || s[0]) ? 8'h60 : 8'h00);
    p = {1'b0, w} + {1'b0, x};
    t = {1'b0, w} - {1'b0, m} - {8'h00, ~s[0]};
    h = {1'b0, w[3:0]} - {1'b0, m[3:0]} - {4'h0, ~s[0]};
    v = (w[7] ^ m[7]) & (w[7] ^ t[7]);
    {u, d, r} = 11'h000;
    case (op)
      6'h01: {u, d, s[0], r} = {3'b110, s[0], ~m};
      6'h02: {u, d, s[0], r} = {3'b101, s[0], ~m};
      6'h03: {u, d, s[0], r} = {3'b010, s[0] | p[8], p[7:0]};
      6'h04: {u, d, s[0], r} = {3'b110, s[0], m - 8'h01};
      6'h05: {u, d, s[0], r} = {3'b101, s[0], m - 8'h01};
      6'h06: {u, d, s[0], r} = {3'b110, s[0], m + 8'h01};
      6'h07: {u, d, s[0], r} = {3'b101, s[0], m + 8'h01};
      6'h0a: {u, d, s[0], r} = {3'b001, s[0], m};
      6'h0b: {u, d, s[0], r} = {3'b001, s[0], i};
      6'h0c: {u, d, s[0], r} = {3'b010, s[0], w};
      6'h0d: {u, d, s[0], r} = {3'b101, s[0], w | m};
      6'h0e: {u, d, s[0], r} = {3'b101, s[0], w | i};
      6'h0f: {u, d, s[0], r} = {3'b110, s[0], w | m};
      6'h13: {u, d, s[0], r} = {3'b010, s[0], m[6:0], m[7]};
      6'h14: {u, d, s[0], r} = {3'b001, s[0], m[6:0], m[7]};
      6'h15: {u, d, s[0], r} = {3'b010, m, s[0]};
      6'h16: {u, d, s[0], r} = {3'b001, m, s[0]};
      6'h17: {u, d, s[0], r} = {3'b010, s[0], m[0], m[7:1]};
      6'h18: {u, d, s[0], r} = {3'b001, s[0], m[0], m[7:1]};
      6'h19: {u, d, s[0], r} = {3'b010, m[0], s[0], m[7:1]};
      6'h1a: {u, d, s[0], r} = {3'b001, m[0], s[0], m[7:1]};
      6'h1b: {u, d, s[0], r} = {3'b101, ~t[8], t[7:0]};
      default: u = 1'b0;
    endcase
    if (op == 6'h1b) {s[7:6], s[3], s[1]} = {(t[7:0] == 8'h00) & s[2], t[7] ^ v, v, ~h[4]};
    if (u) s[2] = (r == 8'h00);
    if (d[0]) w = r;
    if (d[1]) m = r;
    return {w, m, s};
  endfunction

  // --------
  // main sequence
  // --------
  initial begin
    seed = 32'hb55f;
    {rst, cyc, stb, we, adr, sel, dat, irq_req} = {4'h8, 8'h00, 4'hf, 32'h0, 1'b0};
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped", q, 32'h0);
    // first pass uses w=00, m=ff for wrap and borrow corners
    for (int n = 0; n < 84; n++) begin
      op = 6'(n % 28);
      if (op inside {6'h08, 6'h09, [6'h10:6'h12]}) continue;
      {w, m} = (n < 28) ? 16'h00ff : 16'($random(seed));
      {a, i, s} = 24'($random(seed)) & 24'hffffcf;
      wb(1'b1, CIU_A_WREG, {24'h0, w});
      wb(1'b1, CIU_A_STATUS, {24'h0, s});
      wb(1'b1, CIU_A_MADDR, {24'h0, a});
      wb(1'b1, CIU_A_MDATA, {24'h0, m});
      run({8'h00, i, a, 2'b00, op});
      e = model(op, w, m, i, s);
      wb(1'b0, CIU_A_WREG, 32'h0);
      chk("w", q, {24'h0, e[23:16]});
      wb(1'b0, CIU_A_MDATA, 32'h0);
      chk("mem", q, {24'h0, e[15:8]});
      wb(1'b0, CIU_A_STATUS, 32'h0);
      chk("flags", q & 32'hcf, {24'h0, e[7:0]});
    end
    $display("test data ops done");
    wb(1'b1, CIU_A_STATUS, 32'h0);
    t = 13'($random(seed));
    run({3'h0, t, 16'h0009});
    wb(1'b0, CIU_A_PC, 32'h0);
    chk("jump pc", q, {19'h0, t});
    for (int k = 0; k < 3; k++) begin
      wb(1'b1, CIU_A_STACK, {19'h0, t + 13'(k)});
      run({16'h00a5, 10'h000, 6'(6'h10 + k)});
      wb(1'b0, CIU_A_PC, 32'h0);
      chk("exit pc", q, {19'h0, t + 13'(k)});
    end
    wb(1'b0, CIU_A_WREG, 32'h0);
    chk("exit w", q, 32'ha5);
    wb(1'b0, CIU_A_STATUS, 32'h0);
    chk("enable", q & 32'h1ff, 32'h100);
    irq_req <= 1'b1;
    wb(1'b1, CIU_A_STACK, {19'h0, t});
    irq_req <= 1'b0;
    run(32'h12);
    wb(1'b0, CIU_A_PC, 32'h0);
    chk("vector", q, 32'h4);
    chk("irq taken", {24'h0, n_ack}, 32'h1);
    $display("test branches done");
    run(32'h08);
    chk("stop", {31'h0, cstop}, 32'h1);
    wb(1'b0, CIU_A_STATUS, 32'h0);
    chk("halt", q & 32'h430, 32'h410);
    wb(1'b0, CIU_A_WDT, 32'h0);
    chk("wdt", q, 32'h0);
    wb(1'b1, CIU_A_INSTR, 32'h0);
    wb(1'b0, CIU_A_MDATA, 32'h0);
    chk("kept", q, {24'h0, e[15:8]});
    chk("awake", {31'h0, cstop}, 32'h0);
    $display("test power down done");
    results();
  end

  // about fifteen times the expected run length
  initial begin
    #1200000;
    err_count++;
    results();
  end
endmodule
